//--- hdl/pll_pkg.sv
package pll_pkg;

  // clock and timing
  localparam int CLK_MHZ  = 20;
  localparam int LOCK_NS  = 5;
  localparam int LOCK_RAW = (LOCK_NS * CLK_MHZ) / 1000;
  localparam int LOCK_CYC = (LOCK_RAW < 1) ? 1 : LOCK_RAW;
  localparam int ABL_CYC  = 2;

  // prescaler structure
  localparam int PRE_STAGES = 16;
  localparam logic [2:0] CORE_TOP_LO = 3'h3;
  localparam logic [2:0] CORE_TOP_HI = 3'h4;

  // register indices, byte address is index times four
  localparam logic [2:0] IDX_MODE    = 3'h0;
  localparam logic [2:0] IDX_MAIN    = 3'h1;
  localparam logic [2:0] IDX_SWALLOW = 3'h2;
  localparam logic [2:0] IDX_REF     = 3'h3;
  localparam logic [2:0] IDX_CAL     = 3'h4;
  localparam logic [2:0] IDX_CTRL    = 3'h5;
  localparam logic [2:0] IDX_STATUS  = 3'h6;
  localparam logic [2:0] IDX_NONE    = 3'h7;

  // field positions
  localparam int CAL_START_POS  = 0;
  localparam int CAL_INIT_POS   = 1;
  localparam int CTRL_SEL_POS   = 0;
  localparam int CTRL_SWING_POS = 4;

  // power-on defaults
  localparam logic [7:0] DEF_MODE    = 8'h00;
  localparam logic [8:0] DEF_MAIN    = 9'h040;
  localparam logic [5:0] DEF_SWALLOW = 6'h00;
  localparam logic [8:0] DEF_REF     = 9'h018;
  localparam logic [7:0] DEF_CAL     = 8'h00;
  localparam logic [7:0] DEF_CTRL    = 8'h37;
  localparam logic [7:0] MODE_PD     = 8'h00;

  // calibration
  localparam logic [4:0] BAND_MID  = 5'h10;
  localparam logic [2:0] BAND_MSB  = 3'h4;

  typedef enum logic [1:0] {
    CAL_IDLE,
    CAL_SYNC,
    CAL_MEAS,
    CAL_DONE
  } cal_e;

endpackage

//--- hdl/prescaler_dual_mod.sv
`timescale 1ns/10ps
module prescaler_dual_mod #(
  parameter int STAGES = pll_pkg::PRE_STAGES
) (
  // clock and reset
  input  wire logic clk_sys,
  input  wire logic rst_n,
  // vco side
  input  wire logic vco_tick,
  input  wire logic mod_hi,
  // counter side
  output logic      pre_tick
);

  localparam int SW = $clog2(STAGES);
  localparam logic [SW-1:0] LAST = SW'(STAGES - 1);

  typedef struct packed {
    logic [2:0]    core;
    logic [SW-1:0] stage;
    logic          pulse;
  } pre_s;

  pre_s s;
  pre_s next_s;
  logic last;
  logic [2:0] top;

  assign last = (s.stage == LAST);
  // one five-count core cycle per frame when the modulus is high
  assign top  = (last && mod_hi) ? pll_pkg::CORE_TOP_HI : pll_pkg::CORE_TOP_LO; // RL2

  always_comb
  begin
    next_s       = s;
    next_s.pulse = 1'b0;
    if (vco_tick)
    begin
      if (s.core >= top) // RL3
      begin
        next_s.core  = 3'h0;
        next_s.stage = last ? '0 : s.stage + SW'(1);
        next_s.pulse = last;
      end
      else
        next_s.core = s.core + 3'h1;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      s <= '0;
    else
      s <= next_s;
  end

  assign pre_tick = s.pulse;

  a_core_range: assert property (@(posedge clk_sys) disable iff (!rst_n) // RL3
    s.core <= pll_pkg::CORE_TOP_HI)
    else $error("prescaler core left its 4/5 range");

  a_frame_wrap: assert property (@(posedge clk_sys) disable iff (!rst_n) // RL2
    s.pulse |-> (s.stage == '0) && (s.core == 3'h0))
    else $error("prescaler output not at frame wrap");

endmodule // prescaler_dual_mod

//--- hdl/pll_synth_core.sv
// Behaviour
// RL1: reference divided by 9-bit ratio feeds detector
// RL2: VCO prescaled by 64 or 65
// RL3: prescaler built on 4/5 core
// RL4: 6-bit swallow, 9-bit main, N=B*64+A
// RL5: host keeps A<=63, B>A, N 4096..32767
// RL6: detector pulses with fixed minimum overlap
// RL7: lock when up/down edges nearly coincide
// RL8: lock output high in power-down
// RL9: 3-bit code gives code+1 pump current
// RL10: calibration inhibits pump, forces pins mid-supply
// RL11: sub-band selection covers 32 values
// RL12: calibration starts on start-bit rising edge
// RL13: keep sub-band nearest target frequency
// RL14: done_n falls, then pump re-enabled
// RL15: host sets start after ratio change
// RL16: host runs reference before calibrating
// RL17: init pulse resets calibrator, automatic at power-on
// RL18: calibration lasts about seven detector periods; the code takes one sync wait plus five measuring periods
// RL19: host calibrates at detector rate up to 1MHz
// RL20: 2-bit code selects four swing levels
// RL21: ratios loaded over the register bus
// RL22: power-on loads default control values
// RL23: high modulus until swallow expires, then low
// RL24: done_n high during run; retrigger needs start low
`timescale 1ns/10ps
module pll_synth_core (
  // clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  // ahb-lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  // clock pins
  input  wire logic        ref_in,
  input  wire logic        vco_in,
  // detector and pump
  output logic             pfd_up,
  output logic             pfd_dn,
  output logic [3:0]       pump_level,
  output logic             pump_current_pin_mid,
  output logic             tuning_voltage_pin_mid,
  output logic             lock_detect,
  output logic             ref_div_tick,
  output logic             fb_div_tick,
  // vco control
  output logic             calib_done_n,
  output logic [4:0]       vco_subband,
  output logic [1:0]       vco_swing,
  output logic [7:0]       func_mode,
  output logic             power_down
);

  typedef struct packed {
    logic [7:0]    mode;
    logic [8:0]    main_cnt;
    logic [5:0]    swal;
    logic [8:0]    ref_ratio;
    logic [7:0]    cal;
    logic [7:0]    ctrl;
    logic          dph;
    logic          dwr;
    logic [2:0]    didx;
    logic [31:0]   rdata;
    logic          ref_s1;
    logic          ref_s2;
    logic          ref_s3;
    logic          vco_s1;
    logic          vco_s2;
    logic          vco_s3;
    logic [8:0]    r_cnt;
    logic          ref_pulse;
    logic [5:0]    a_left;
    logic [8:0]    b_cnt;
    logic          fb_pulse;
    logic          up;
    logic          dn;
    logic [1:0]    abl;
    logic          up_out;
    logic          dn_out;
    logic [3:0]    gap;
    logic          gap_run;
    logic          locked;
    logic          lock_out;
    logic          pd;
    logic [3:0]    level;
    pll_pkg::cal_e cal_st;
    logic [4:0]    band;
    logic [2:0]    bit_idx;
    logic          fb_seen;
    logic          armed;
    logic          start_prev;
    logic          done_n;
    logic          mid;
  } core_s;

  localparam core_s RST_VAL = '{
    mode:      pll_pkg::DEF_MODE,
    main_cnt:  pll_pkg::DEF_MAIN,
    swal:      pll_pkg::DEF_SWALLOW,
    ref_ratio: pll_pkg::DEF_REF,
    cal:       pll_pkg::DEF_CAL,
    ctrl:      pll_pkg::DEF_CTRL,
    pd:        1'b1,
    lock_out:  1'b1,
    level:     4'h8,
    cal_st:    pll_pkg::CAL_IDLE,
    band:      pll_pkg::BAND_MID,
    armed:     1'b1,
    done_n:    1'b1,
    default:   '0
  };

  core_s s;
  core_s next_s;
  logic  pre_tick;
  logic  ref_tick;
  logic  vco_tick;
  logic  busy;
  logic  start_bit;
  logic  init_bit;
  logic  trig;
  logic  up_set;
  logic  dn_set;
  logic  accept;
  logic  hit;

  assign ref_tick  = s.ref_s2 & ~s.ref_s3;
  assign vco_tick  = s.vco_s2 & ~s.vco_s3;
  assign busy      = (s.cal_st != pll_pkg::CAL_IDLE);
  assign start_bit = s.cal[pll_pkg::CAL_START_POS];
  assign init_bit  = s.cal[pll_pkg::CAL_INIT_POS];
  assign trig      = start_bit & ~s.start_prev & s.armed & ~busy & ~init_bit; // RL12
  assign up_set    = s.ref_pulse & ~s.up;
  assign dn_set    = s.fb_pulse & ~s.dn;
  assign accept    = hsel & hready & htrans[1];
  assign hit       = (haddr[31:5] == 27'h0) & (haddr[1:0] == 2'h0) & (hsize == 3'h2);

  prescaler_dual_mod #(
    .STAGES (pll_pkg::PRE_STAGES)
  ) u_prescaler (
    .clk_sys  (clk_sys),
    .rst_n    (rst_n),
    .vco_tick (vco_tick),
    .mod_hi   (s.a_left != 6'h00), // RL23
    .pre_tick (pre_tick)
  );

  always_comb
  begin
    next_s = s;

    // pin synchronisers
    next_s.ref_s1 = ref_in;
    next_s.ref_s2 = s.ref_s1;
    next_s.ref_s3 = s.ref_s2;
    next_s.vco_s1 = vco_in;
    next_s.vco_s2 = s.vco_s1;
    next_s.vco_s3 = s.vco_s2;

    // bus data phase write, ratios come only from here
    if (s.dph && s.dwr)
    begin
      unique case (s.didx) // RL21
        pll_pkg::IDX_MODE:    next_s.mode      = hwdata[7:0];
        pll_pkg::IDX_MAIN:    next_s.main_cnt  = hwdata[8:0];
        pll_pkg::IDX_SWALLOW: next_s.swal      = hwdata[5:0];
        pll_pkg::IDX_REF:     next_s.ref_ratio = hwdata[8:0];
        pll_pkg::IDX_CAL:     next_s.cal       = hwdata[7:0];
        pll_pkg::IDX_CTRL:    next_s.ctrl      = hwdata[7:0];
        default:              next_s.cal       = s.cal;
      endcase
    end
    next_s.dph  = accept;
    next_s.dwr  = hwrite;
    next_s.didx = (accept && hit) ? haddr[4:2] : pll_pkg::IDX_NONE;
    // read data picked in address phase, from post-write values
    if (accept && !hwrite)
    begin
      unique case (next_s.didx)
        pll_pkg::IDX_MODE:    next_s.rdata = {24'h0, next_s.mode};
        pll_pkg::IDX_MAIN:    next_s.rdata = {23'h0, next_s.main_cnt};
        pll_pkg::IDX_SWALLOW: next_s.rdata = {26'h0, next_s.swal};
        pll_pkg::IDX_REF:     next_s.rdata = {23'h0, next_s.ref_ratio};
        pll_pkg::IDX_CAL:     next_s.rdata = {24'h0, next_s.cal};
        pll_pkg::IDX_CTRL:    next_s.rdata = {24'h0, next_s.ctrl};
        pll_pkg::IDX_STATUS:
          next_s.rdata = {23'h0, s.pd, s.mid, s.lock_out, s.done_n, s.band};
        default:              next_s.rdata = 32'h0;
      endcase
    end

    // reference divider
    next_s.ref_pulse = 1'b0;
    if (ref_tick)
    begin
      if (({1'b0, s.r_cnt} + 10'h001) >= {1'b0, s.ref_ratio}) // RL1
      begin
        next_s.r_cnt     = 9'h000;
        next_s.ref_pulse = 1'b1;
      end
      else
        next_s.r_cnt = s.r_cnt + 9'h001;
    end

    // swallow and main counters
    next_s.fb_pulse = 1'b0;
    if (busy && s.ref_pulse)
    begin
      next_s.b_cnt  = 9'h000;
      next_s.a_left = next_s.swal;
    end
    else if (pre_tick)
    begin
      if (s.a_left != 6'h00)
        next_s.a_left = s.a_left - 6'h01; // RL23
      if (({1'b0, s.b_cnt} + 10'h001) >= {1'b0, s.main_cnt}) // RL4
      begin
        next_s.b_cnt    = 9'h000;
        // a swallow write landing on the reload edge is taken at once
        next_s.a_left   = next_s.swal;
        next_s.fb_pulse = 1'b1;
      end
      else
        next_s.b_cnt = s.b_cnt + 9'h001;
    end

    // phase detector with fixed overlap before reset
    if (s.ref_pulse)
      next_s.up = 1'b1;
    if (s.fb_pulse)
      next_s.dn = 1'b1;
    if (s.up && s.dn)
    begin
      if (s.abl == 2'(pll_pkg::ABL_CYC - 1)) // RL6
      begin
        next_s.up  = 1'b0;
        next_s.dn  = 1'b0;
        next_s.abl = 2'h0;
      end
      else
        next_s.abl = s.abl + 2'h1;
    end
    if (s.pd)
    begin
      next_s.up  = 1'b0;
      next_s.dn  = 1'b0;
      next_s.abl = 2'h0;
    end

    // lock detect on up/down rising edge spacing
    if (up_set && dn_set)
    begin
      next_s.locked  = 1'b1; // RL7
      next_s.gap_run = 1'b0;
    end
    else if (up_set || dn_set)
    begin
      if (s.gap_run)
      begin
        next_s.locked  = (s.gap < 4'(pll_pkg::LOCK_CYC)); // RL7
        next_s.gap_run = 1'b0;
      end
      else
      begin
        next_s.gap_run = 1'b1;
        next_s.gap     = 4'h1;
      end
    end
    else if (s.gap_run && s.gap != 4'hF)
      next_s.gap = s.gap + 4'h1;

    next_s.pd       = (next_s.mode == pll_pkg::MODE_PD);
    next_s.lock_out = next_s.locked | s.pd; // RL8
    next_s.level    = {1'b0, s.ctrl[pll_pkg::CTRL_SEL_POS +: 3]} + 4'h1; // RL9

    // sub-band calibration, binary search from the top bit
    next_s.start_prev = start_bit;
    if (!start_bit)
      next_s.armed = 1'b1; // RL24
    if (init_bit)
    begin
      next_s.cal_st = pll_pkg::CAL_IDLE; // RL17
      next_s.band   = pll_pkg::BAND_MID;
      next_s.done_n = 1'b1;
    end
    else
    begin
      unique case (s.cal_st)
        pll_pkg::CAL_IDLE:
          if (trig)
          begin
            next_s.cal_st  = pll_pkg::CAL_SYNC; // RL12
            next_s.band    = pll_pkg::BAND_MID; // RL11
            next_s.bit_idx = pll_pkg::BAND_MSB;
            next_s.done_n  = 1'b1; // RL24
            next_s.armed   = 1'b0;
          end
        pll_pkg::CAL_SYNC:
          if (s.ref_pulse)
          begin
            next_s.cal_st  = pll_pkg::CAL_MEAS;
            next_s.fb_seen = 1'b0;
          end
        pll_pkg::CAL_MEAS:
        begin
          if (s.fb_pulse)
            next_s.fb_seen = 1'b1;
          if (s.ref_pulse)
          begin
            // feedback ahead of reference means band too fast
            if (s.fb_seen || s.fb_pulse)
              next_s.band[s.bit_idx] = 1'b0; // RL13
            next_s.fb_seen = 1'b0;
            if (s.bit_idx == 3'h0)
            begin
              next_s.cal_st = pll_pkg::CAL_DONE; // RL18
              next_s.done_n = 1'b0; // RL14
            end
            else
            begin
              next_s.band[s.bit_idx - 3'h1] = 1'b1; // RL13
              next_s.bit_idx = s.bit_idx - 3'h1;
            end
          end
        end
        pll_pkg::CAL_DONE:
          next_s.cal_st = pll_pkg::CAL_IDLE; // RL14
      endcase
    end

    // pump held off and pins parked while calibrating
    next_s.mid    = (next_s.cal_st != pll_pkg::CAL_IDLE); // RL10
    next_s.up_out = next_s.up & ~next_s.mid; // RL10
    next_s.dn_out = next_s.dn & ~next_s.mid;
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      s <= RST_VAL; // RL22 RL17
    else
      s <= next_s;
  end

  assign hreadyout              = 1'b1;
  assign hresp                  = 1'b0;
  assign hrdata                 = s.rdata;
  assign pfd_up                 = s.up_out;
  assign pfd_dn                 = s.dn_out;
  assign pump_level             = s.level;
  assign pump_current_pin_mid   = s.mid;
  assign tuning_voltage_pin_mid = s.mid;
  assign lock_detect            = s.lock_out;
  assign ref_div_tick           = s.ref_pulse;
  assign fb_div_tick            = s.fb_pulse;
  assign calib_done_n           = s.done_n;
  assign vco_subband            = s.band;
  assign vco_swing              = s.ctrl[pll_pkg::CTRL_SWING_POS +: 2]; // RL20
  assign func_mode              = s.mode;
  assign power_down             = s.pd;

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);

  sequence s_cal_kick;
    trig;
  endsequence

  sequence s_cal_run;
    busy && calib_done_n;
  endsequence

  a_ref_div_wrap: assert property ( // RL1
    s.ref_pulse |-> s.r_cnt == 9'h000 && $past(ref_tick))
    else $error("reference pulse without wrap");

  a_fb_reload: assert property ( // RL23
    s.fb_pulse && !busy |-> s.b_cnt == 9'h000 && s.a_left == s.swal)
    else $error("feedback counters not reloaded");

  a_pfd_overlap: assert property ( // RL6
    $rose(s.up && s.dn) && !s.pd |-> (s.up && s.dn)[*2] ##1 !(s.up && s.dn))
    else $error("detector overlap width wrong");

  a_lock_window: assert property ( // RL7
    up_set && dn_set && !s.pd |=> lock_detect)
    else $error("coincident edges did not give lock");

  a_lock_pd: assert property ( // RL8
    s.pd |=> lock_detect)
    else $error("lock low in power-down");

  a_pump_level: assert property ( // RL9
    ##1 pump_level == {1'b0, $past(s.ctrl[2:0])} + 4'h1)
    else $error("pump level not code plus one");

  a_cal_inhibit: assert property ( // RL10
    busy |-> !pfd_up && !pfd_dn && pump_current_pin_mid && tuning_voltage_pin_mid)
    else $error("pump active during calibration");

  a_cal_start: assert property ( // RL12
    s_cal_kick |=> s_cal_run ##1 (busy throughout s_cal_run))
    else $error("calibration did not start on edge");

  a_cal_finish: assert property ( // RL14
    $fell(calib_done_n) |-> busy ##1 !busy)
    else $error("pump not re-enabled after done");

  a_cal_retrig: assert property ( // RL24
    start_bit && s.start_prev && !busy |=> !busy)
    else $error("held start bit retriggered");

endmodule // pll_synth_core

//--- verif/pll_pins_model.sv
`timescale 1ns/10ps
module pll_pins_model #(
  parameter int REF_HALF = 4,
  parameter int VCO_HALF = 2
) (
  // clock
  input  wire logic clk_sys,
  // control
  input  wire logic run,
  // pins
  output logic      ref_in,
  output logic      vco_in
);
  int ref_cnt = 0;
  int vco_cnt = 0;

  // both pins stand still low until run
  always @(posedge clk_sys)
  begin
    if (!run)
    begin
      ref_cnt <= 0;
      vco_cnt <= 0;
      ref_in  <= 1'b0;
      vco_in  <= 1'b0;
    end
    else
    begin
      ref_cnt <= (ref_cnt == REF_HALF - 1) ? 0 : ref_cnt + 1;
      vco_cnt <= (vco_cnt == VCO_HALF - 1) ? 0 : vco_cnt + 1;
      if (ref_cnt == REF_HALF - 1)
        ref_in <= ~ref_in;
      if (vco_cnt == VCO_HALF - 1)
        vco_in <= ~vco_in;
    end
  end
endmodule // pll_pins_model

//--- verif/pll_synth_core_test.sv
`timescale 1ns/10ps
module pll_synth_core_test;
  logic        clk_sys = 1'b0;
  logic        rst_n;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  logic        hreadyout;
  logic        hresp;
  logic [31:0] hrdata;
  logic        ref_in;
  logic        vco_in;
  logic        run;
  logic        pfd_up;
  logic        pfd_dn;
  logic [3:0]  pump_level;
  logic        pump_mid;
  logic        tune_mid;
  logic        lock_detect;
  logic        ref_div_tick;
  logic        fb_div_tick;
  logic        calib_done_n;
  logic [4:0]  vco_subband;
  logic [1:0]  vco_swing;
  logic [7:0]  func_mode;
  logic        power_down;
  int          n_errors;
  int          checked;

  pll_synth_core dut_u (
    .clk_sys(clk_sys), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .ref_in(ref_in),
    .vco_in(vco_in), .pfd_up(pfd_up), .pfd_dn(pfd_dn), .pump_level(pump_level),
    .pump_current_pin_mid(pump_mid), .tuning_voltage_pin_mid(tune_mid),
    .lock_detect(lock_detect), .ref_div_tick(ref_div_tick), .fb_div_tick(fb_div_tick),
    .calib_done_n(calib_done_n), .vco_subband(vco_subband), .vco_swing(vco_swing),
    .func_mode(func_mode), .power_down(power_down)
  );

  pll_pins_model pins_u (.clk_sys(clk_sys), .run(run), .ref_in(ref_in), .vco_in(vco_in));

  always #25 clk_sys = ~clk_sys;

  task automatic conclude();
    $display("checks %0d mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic timeout();
    n_errors++;
    $display("[ERR] wait expected event seen none");
    conclude();
  endtask

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("[ERR] %s expected %0h seen %0h", what, exp, seen);
    end
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask

  // one single transfer, waits on hready in both phases
  task automatic ahb(input logic wr, input logic [31:0] addr, input logic [31:0] wdata,
                     output logic [31:0] rdata);
    int n;
    @(posedge clk_sys);
    htrans <= 2'h2;
    haddr  <= addr;
    hwrite <= wr;
    n = 0;
    do
    begin
      @(posedge clk_sys);
      n++;
    end while (hreadyout !== 1'b1 && n < 50);
    if (n >= 50)
      timeout();
    htrans <= 2'h0;
    hwdata <= wdata;
    n = 0;
    do
    begin
      @(posedge clk_sys);
      n++;
    end while (hreadyout !== 1'b1 && n < 50);
    if (n >= 50)
      timeout();
    rdata = hrdata;
  endtask

  task automatic wr(input logic [2:0] idx, input logic [31:0] d);
    logic [31:0] unused;
    ahb(1'b1, {27'h0, idx, 2'h0}, d, unused);
  endtask

  task automatic rd(input logic [2:0] idx, output logic [31:0] d);
    ahb(1'b0, {27'h0, idx, 2'h0}, 32'h0, d);
  endtask

  task automatic wait_tick(input logic fb, input int lim, output int cyc);
    cyc = 0;
    do
    begin
      @(posedge clk_sys);
      #1;
      cyc++;
    end while ((fb ? fb_div_tick : ref_div_tick) !== 1'b1 && cyc < lim);
    if (cyc >= lim)
      timeout();
  endtask

  task automatic t_defaults();
    logic [31:0] d;
    settle(1);
    check("pump_level", pump_level, 4'h8);
    check("vco_swing", vco_swing, 2'h3);
    check("lock_detect", lock_detect, 1'b1);
    check("calib_done_n", calib_done_n, 1'b1);
    check("power_down", power_down, 1'b1);
    rd(pll_pkg::IDX_MAIN, d);
    check("main", d, 32'(pll_pkg::DEF_MAIN));
    rd(pll_pkg::IDX_REF, d);
    check("ref", d, 32'(pll_pkg::DEF_REF));
    rd(pll_pkg::IDX_CTRL, d);
    check("ctrl", d, 32'(pll_pkg::DEF_CTRL));
    wr(pll_pkg::IDX_STATUS, 32'h0);
    rd(pll_pkg::IDX_STATUS, d);
    check("status pd", d[8], 1'b1);
    ahb(1'b0, 32'h0000001C, 32'h0, d);
    check("unmapped", d, 32'h0);
    check("hresp", hresp, 1'b0);
    $display("test defaults done");
  endtask

  task automatic t_pump();
    for (int i = 0; i < 8; i++)
    begin
      wr(pll_pkg::IDX_CTRL, 32'(i) | (32'(i % 4) << 4));
      settle(2);
      check("pump_level", pump_level, 32'(i + 1));
      check("vco_swing", vco_swing, 32'(i % 4));
    end
    $display("test pump done");
  endtask

  task automatic t_divide();
    int cyc;
    logic [31:0] d;
    int b[2] = '{64, 66};
    int a[2] = '{63, 0};
    @(posedge clk_sys);
    run <= 1'b1;
    wr(pll_pkg::IDX_MODE, 32'h1);
    wr(pll_pkg::IDX_REF, 32'h3);
    settle(2);
    check("power_down", power_down, 1'b0);
    check("func_mode", func_mode, 32'h1);
    wait_tick(1'b0, 200, cyc);
    wait_tick(1'b0, 200, cyc);
    check("ref period", cyc, 32'h18);
    for (int k = 0; k < 2; k++)
    begin
      // swallow first, so a reload between the writes already takes it
      wr(pll_pkg::IDX_SWALLOW, 32'(a[k]));
      wr(pll_pkg::IDX_MAIN, 32'(b[k]));
      rd(pll_pkg::IDX_MAIN, d);
      check("main readback", d, 32'(b[k]));
      repeat (2) wait_tick(1'b1, 20000, cyc);
      check("fb period", cyc, 32'((64 * b[k] + a[k]) * 4));
    end
    check("lock_detect", lock_detect, 1'b0);
    $display("test divide done");
  endtask

  task automatic t_calib();
    int cyc;
    int ticks;
    wr(pll_pkg::IDX_CAL, 32'h1);
    settle(3);
    check("pump pin mid", pump_mid, 1'b1);
    check("tune pin mid", tune_mid, 1'b1);
    check("pump pulses", pfd_up | pfd_dn, 1'b0);
    check("done_n busy", calib_done_n, 1'b1);
    ticks = 0;
    cyc = 0;
    while (calib_done_n === 1'b1 && cyc < 1000)
    begin
      @(posedge clk_sys);
      #1;
      cyc++;
      if (ref_div_tick === 1'b1)
        ticks++;
    end
    if (cyc >= 1000)
      timeout();
    check("cal length", ticks >= 5 && ticks <= 7, 1'b1);
    // feedback never arrives within a reference period, so every step goes up
    check("subband", vco_subband, 32'h1F);
    settle(2);
    check("pin release", pump_mid, 1'b0);
    check("done_n", calib_done_n, 1'b0);
    wr(pll_pkg::IDX_CAL, 32'h1);
    settle(4);
    check("held start", pump_mid, 1'b0);
    wr(pll_pkg::IDX_CAL, 32'h0);
    wr(pll_pkg::IDX_CAL, 32'h3);
    settle(4);
    check("init holds", pump_mid, 1'b0);
    check("init band", vco_subband, 32'(pll_pkg::BAND_MID));
    check("init done_n", calib_done_n, 1'b1);
    wr(pll_pkg::IDX_CAL, 32'h0);
    wr(pll_pkg::IDX_CAL, 32'h1);
    settle(3);
    check("retrigger", pump_mid, 1'b1);
    check("done_n rerun", calib_done_n, 1'b1);
    $display("test calib done");
  endtask

  initial
  begin
    rst_n = 1'b0;
    hsel = 1'b1;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    run = 1'b0;
    n_errors = 0;
    checked = 0;
    repeat (12) @(posedge clk_sys);
    rst_n <= 1'b1;
    t_defaults();
    t_pump();
    t_divide();
    t_calib();
    conclude();
  end
endmodule // pll_synth_core_test
